//--- pds_cfg.svh
// Timing counts and field positions for the panel display scanner.
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH

// ==========================================================================
// Clock and panel timing
// ==========================================================================
`define PDS_CLK_PERIOD_NS 10
`define PDS_PANEL_PERIOD_NS 1000
`define PDS_PANEL_CYCLES (`PDS_PANEL_PERIOD_NS / `PDS_CLK_PERIOD_NS)
`define PDS_PANEL_HALF (`PDS_PANEL_CYCLES / 2)
`define PDS_DIV_W 7

// ==========================================================================
// Counter and buffer layout
// ==========================================================================
`define PDS_CNT_W 8
`define PDS_NIB_W 4
`define PDS_BUF_W 16
`define PDS_SECTIONS 4
`define PDS_CNT_INIT 8'h00
`define PDS_BUF_INIT 16'h0000

`endif

//--- pds_pkg.sv
// Types shared by the panel display scanner.
package pds_pkg;

   // ========================================================================
   // Panel clock states, Gray coded along off, high, low
   // ========================================================================
   typedef enum logic [1:0] {
      PDS_PCLK_OFF = 2'b00,
      PDS_PCLK_HIGH = 2'b01,
      PDS_PCLK_LOW = 2'b11
   } pds_pclk_state_t;

endpackage : pds_pkg

//--- pds_panel_display_scanner.sv
// Panel scan counter, serial multiplexer and lamp shift buffer.
//
// What this block does
// - Eight-bit counter steps once per panel clock through 256 states.
// - Counter only counts up; nothing loads or clears it.
// - Low nibble wraps 0..15 and carries into the high nibble.
// - Scan select is the counter low nibble inverted bit by bit.
// - Shift control is high only when the high nibble is zero.
// - Shift control high shifts the serial bit in; low holds the buffer.
// - States 0..15 scan sixteen bits; states 16..255 hold for display.
// - Panel clock period is about one microsecond.
// - Buffer is four chained 4-bit sections, each feeding the next.
// - Buffer has no parallel load or reset; only shift control steers it.
// - Each buffer bit drives one lamp, lit when the bit is one.
// - Counter steps on panel clock rise; buffer shifts on its fall.
// - Count zero selects input 15; count 15 selects input 0.
// - Panel clock stops while power good is low, runs once it is high.
// - Multiplexer passes its bit only while strobe is low, inverted.
`timescale 1ns/100ps
`include "pds_cfg.svh"

module pds_panel_display_scanner (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic power_good, // Supply good level, high while powered.
   input wire logic strobe_b, // Multiplexer strobe, active low.
   input wire logic [15:0] data_path_b, // B-leg data path bits to scan.
   output logic panel_clk, // Derived panel clock level.
   output logic [3:0] scan_select, // Multiplexer select lines.
   output logic shift_display, // Buffer shift control, high shifts.
   output logic serial_bit, // Serial multiplexer output.
   output logic [15:0] lamp // Indicator lamp drives, high lights.
);

   // ========================================================================
   // Multiplexer decode
   // ========================================================================
   // One-of-sixteen select with output inversion; a disabled strobe
   // forces the internal bit low, so the serial line idles high.
   function automatic logic pds_mux_bit(
      input logic [15:0] data,
      input logic [3:0] sel,
      input logic strb_b
   );
      logic pick;
      pick = strb_b ? 1'b0 : data[sel];
      return ~pick;
   endfunction : pds_mux_bit

   // ========================================================================
   // Panel clock generator
   // ========================================================================
   pds_pkg::pds_pclk_state_t pclk_reg;
   pds_pkg::pds_pclk_state_t pclk_next;
   logic [`PDS_DIV_W-1:0] div_reg;
   logic [`PDS_DIV_W-1:0] div_next;
   logic panel_clk_reg;
   logic panel_clk_next;
   logic rise_ev;
   logic fall_ev;

   localparam logic [`PDS_DIV_W-1:0] DIV_LAST =
      `PDS_DIV_W'(`PDS_PANEL_CYCLES - 1);
   localparam logic [`PDS_DIV_W-1:0] DIV_HALF =
      `PDS_DIV_W'(`PDS_PANEL_HALF - 1);

   // Rise comes first when power good arrives, then every full period.
   always_comb begin
      pclk_next = pclk_reg;
      div_next = div_reg;
      rise_ev = 1'b0;
      fall_ev = 1'b0;
      if (!power_good) begin
         pclk_next = pds_pkg::PDS_PCLK_OFF;
         div_next = '0;
      end else begin
         case (pclk_reg)
            pds_pkg::PDS_PCLK_OFF: begin
               rise_ev = 1'b1;
               pclk_next = pds_pkg::PDS_PCLK_HIGH;
               div_next = '0;
            end
            pds_pkg::PDS_PCLK_HIGH: begin
               div_next = div_reg + `PDS_DIV_W'(1);
               if (div_reg == DIV_HALF) begin
                  fall_ev = 1'b1;
                  pclk_next = pds_pkg::PDS_PCLK_LOW;
               end
            end
            pds_pkg::PDS_PCLK_LOW: begin
               div_next = div_reg + `PDS_DIV_W'(1);
               if (div_reg == DIV_LAST) begin
                  rise_ev = 1'b1;
                  pclk_next = pds_pkg::PDS_PCLK_HIGH;
                  div_next = '0;
               end
            end
            default: begin
               pclk_next = pds_pkg::PDS_PCLK_OFF;
               div_next = '0;
            end
         endcase
      end
      // Reset also holds the events off; otherwise the counter would race
      // at the system clock rate while the oscillator is held stopped.
      if (!ce || !rst_b) begin
         pclk_next = pclk_reg;
         div_next = div_reg;
         rise_ev = 1'b0;
         fall_ev = 1'b0;
      end
      panel_clk_next = (pclk_next == pds_pkg::PDS_PCLK_HIGH);
   end

   // Only the oscillator is reset; the scan path has no clear by design.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pclk_reg <= pds_pkg::PDS_PCLK_OFF;
         div_reg <= '0;
         panel_clk_reg <= 1'b0;
      end else begin
         pclk_reg <= pclk_next;
         div_reg <= div_next;
         panel_clk_reg <= panel_clk_next;
      end
   end

   assign panel_clk = panel_clk_reg;

   // ========================================================================
   // Scan counter
   // ========================================================================
   // The power-up value is arbitrary; one full cycle brings the display
   // to a valid image whatever it was.
   logic [`PDS_CNT_W-1:0] cnt_reg = `PDS_CNT_INIT;
   logic [`PDS_CNT_W-1:0] cnt_next;
   logic [3:0] scan_select_reg = 4'hf;
   logic [3:0] scan_select_next;
   logic shift_display_reg = 1'b1;
   logic shift_display_next;

   // The carry from the low nibble into the high one is the plain binary
   // carry of an 8-bit add, and 255 wraps to zero on its own.
   always_comb begin
      cnt_next = cnt_reg;
      if (rise_ev) begin
         cnt_next = cnt_reg + `PDS_CNT_W'(1);
      end
      scan_select_next = ~cnt_next[`PDS_NIB_W-1:0];
      shift_display_next =
         (cnt_next[`PDS_CNT_W-1:`PDS_NIB_W] == 4'h0);
   end

   // No reset input reaches the counter, so nothing outside can clear it.
   always_ff @(posedge clk) begin
      cnt_reg <= cnt_next;
      scan_select_reg <= scan_select_next;
      shift_display_reg <= shift_display_next;
   end

   assign scan_select = scan_select_reg;
   assign shift_display = shift_display_reg;

   // ========================================================================
   // Multiplexer
   // ========================================================================
   // The select settles half a panel period before the buffer samples it.
   assign serial_bit =
      pds_mux_bit(data_path_b, scan_select_reg, strobe_b);

   // ========================================================================
   // Display buffer
   // ========================================================================
   logic [`PDS_BUF_W-1:0] buf_reg = `PDS_BUF_INIT;
   logic [`PDS_BUF_W-1:0] buf_next;
   logic [`PDS_BUF_W-1:0] chain_next;
   logic do_shift;

   assign do_shift = fall_ev & shift_display_reg;

   // Each section after the first takes the last bit of the one before as its serial input.
   genvar g;
   generate
      for (g = 0; g < `PDS_SECTIONS; g++) begin : g_section
         logic sec_in;
         if (g == 0) begin : g_first
            assign sec_in = serial_bit;
         end else begin : g_rest
            assign sec_in = buf_reg[g*`PDS_NIB_W-1];
         end
         assign chain_next[g*`PDS_NIB_W +: `PDS_NIB_W] =
            {buf_reg[g*`PDS_NIB_W +: `PDS_NIB_W-1], sec_in};
      end
   endgenerate

   // Shift or hold is the only choice; there is no load path.
   always_comb begin
      buf_next = buf_reg;
      if (do_shift) begin
         buf_next = chain_next;
      end
   end

   // No reset here either: a stale image is rewritten by the next scan.
   always_ff @(posedge clk) begin
      buf_reg <= buf_next;
   end

   // Lamp drivers follow the buffer bits directly.
   assign lamp = buf_reg;

   // ========================================================================
   // Assertions
   // ========================================================================
   sequence s_rise;
      rise_ev;
   endsequence

   sequence s_fall_shift;
      fall_ev && shift_display_reg;
   endsequence

   a_cnt_step: assert property (@(posedge clk)
      disable iff (!rst_b)
      s_rise |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("Counter did not step on panel clock rise.");

   a_cnt_quiet: assert property (@(posedge clk)
      disable iff (!rst_b)
      !rise_ev |=> $stable(cnt_reg))
      else $error("Counter moved without a panel clock rise.");

   a_nibble_carry: assert property (@(posedge clk)
      disable iff (!rst_b)
      (s_rise and (cnt_reg[3:0] == 4'hf))
      |=> cnt_reg[3:0] == 4'h0 &&
          cnt_reg[7:4] == $past(cnt_reg[7:4]) + 4'h1)
      else $error("Low nibble wrap did not carry.");

   a_select_inv: assert property (@(posedge clk)
      disable iff (!rst_b)
      scan_select == ~cnt_reg[3:0])
      else $error("Scan select is not the inverted low nibble.");

   a_shift_ctl: assert property (@(posedge clk)
      disable iff (!rst_b)
      shift_display == (cnt_reg[7:4] == 4'h0))
      else $error("Shift control does not match high nibble.");

   a_buf_shift: assert property (@(posedge clk)
      disable iff (!rst_b)
      s_fall_shift |=> buf_reg == {$past(buf_reg[14:0]), $past(serial_bit)})
      else $error("Buffer did not shift in the serial bit.");

   a_buf_hold: assert property (@(posedge clk)
      disable iff (!rst_b)
      !(fall_ev && shift_display_reg) |=> $stable(buf_reg))
      else $error("Buffer changed outside a shift.");

   a_hold_phase: assert property (@(posedge clk)
      disable iff (!rst_b)
      (cnt_reg[7:4] != 4'h0) |-> ##1 !do_shift || $past(rise_ev))
      else $error("Buffer shifted during the hold phase.");

   a_edge_gap: assert property (@(posedge clk)
      disable iff (!rst_b)
      (s_rise and ce) ##1 (ce && power_good) [*8] |-> !fall_ev)
      else $error("Buffer fall came too soon after the rise.");

   a_pg_off: assert property (@(posedge clk)
      disable iff (!rst_b)
      (ce && !power_good) |=> pclk_reg == pds_pkg::PDS_PCLK_OFF && !panel_clk)
      else $error("Panel clock ran without power good.");

   a_pg_start: assert property (@(posedge clk)
      disable iff (!rst_b)
      (rst_b && ce && power_good && pclk_reg == pds_pkg::PDS_PCLK_OFF)
      |-> rise_ev)
      else $error("Panel clock did not start on power good.");

   a_mux_out: assert property (@(posedge clk)
      disable iff (!rst_b)
      serial_bit == (strobe_b ? 1'b1 : ~data_path_b[~cnt_reg[3:0]]))
      else $error("Serial bit is not the inverted selected input.");

   a_lamp_map: assert property (@(posedge clk)
      disable iff (!rst_b)
      lamp == buf_reg)
      else $error("Lamps do not follow the buffer.");

   a_pclk_level: assert property (@(posedge clk)
      disable iff (!rst_b)
      panel_clk == (pclk_reg == pds_pkg::PDS_PCLK_HIGH))
      else $error("Panel clock level does not match its state.");

   a_rise_period: assert property (@(posedge clk)
      disable iff (!rst_b)
      (rise_ev && pclk_reg == pds_pkg::PDS_PCLK_LOW)
      |-> div_reg == DIV_LAST)
      else $error("Panel clock rise came at the wrong count.");

   a_fall_point: assert property (@(posedge clk)
      disable iff (!rst_b)
      fall_ev
      |-> pclk_reg == pds_pkg::PDS_PCLK_HIGH && div_reg == DIV_HALF)
      else $error("Panel clock fall came at the wrong count.");

   a_ce_freeze: assert property (@(posedge clk)
      disable iff (!rst_b)
      !ce |=> $stable(cnt_reg) && $stable(buf_reg) && $stable(pclk_reg))
      else $error("State moved while the clock enable was low.");

endmodule : pds_panel_display_scanner

//--- pds_dp_model.sv
// Behavioural model of the processor data path feeding the scanner.
`timescale 1ns/100ps

// ==========================================================================
// Data path and strobe source
// ==========================================================================
module pds_dp_model (
   input wire logic clk, // System clock.
   input wire logic [15:0] word, // Value the data path holds.
   input wire logic blank, // High keeps the multiplexer strobe off.
   output logic [15:0] data_path_b = 16'h0000, // Bits seen by the scanner.
   output logic strobe_b = 1'b0 // Multiplexer strobe, active low.
);

   // The data path changes only on a clock edge, like a register file would.
   always_ff @(posedge clk) begin
      data_path_b <= word;
      strobe_b <= blank;
   end

endmodule : pds_dp_model

//--- pds_panel_display_scanner_tb.sv
// Self-checking testbench for the panel display scanner.
`timescale 1ns/100ps

// Compares a design value with its expectation and counts the result.
`define PDS_CHK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("BAD %0t got %h expected %h", $time, got, exp); \
   end \
end

// ==========================================================================
// Bench top
// ==========================================================================
module pds_panel_display_scanner_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic power_good = 1'b1;
   logic ce = 1'b1;
   logic blank = 1'b0;
   logic [15:0] word = 16'h5a3c;
   logic [15:0] data_path_b;
   logic strobe_b;
   logic panel_clk;
   logic [3:0] scan_select;
   logic shift_display;
   logic serial_bit;
   logic [15:0] lamp;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   // The clock enable is driven so that one scenario can freeze the block.
   pds_panel_display_scanner dut (
      .clk(clk), .rst_b(rst_b), .ce(ce), .power_good(power_good),
      .strobe_b(strobe_b), .data_path_b(data_path_b), .panel_clk(panel_clk),
      .scan_select(scan_select), .shift_display(shift_display),
      .serial_bit(serial_bit), .lamp(lamp));

   pds_dp_model model (
      .clk(clk), .word(word), .blank(blank), .data_path_b(data_path_b),
      .strobe_b(strobe_b));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 clk = ~clk;
   end

   // Two full scan cycles need about 53000 cycles, so this leaves margin.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         test_done();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // Waits, bounded, until panel_clk (0) or shift_display (1) reaches lvl.
   task automatic wait_level(input bit which, input logic lvl,
                             input int lim, output int n);
      n = 0;
      while (((which ? shift_display : panel_clk) !== lvl) && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_level

   // Waits for a fresh rise of the panel clock.
   task automatic next_rise();
      int n;
      wait_level(1'b0, 1'b0, 200, n);
      wait_level(1'b0, 1'b1, 200, n);
   endtask : next_rise

   // Panel clock is high for 50 cycles and low for 50.
   task automatic clock_task();
      int n;
      next_rise();
      wait_level(1'b0, 1'b0, 200, n);
      `PDS_CHK(n, 50)
      wait_level(1'b0, 1'b1, 200, n);
      `PDS_CHK(n, 50)
   endtask : clock_task

   // Select steps down by one per rise and the serial bit is inverted data.
   task automatic mux_task();
      logic [3:0] sel;
      next_rise();
      sel = scan_select;
      for (int i = 0; i < 16; i++) begin
         next_rise();
         sel = sel - 4'h1;
         `PDS_CHK(scan_select, sel)
         `PDS_CHK(serial_bit, ~word[sel])
      end
      @(posedge clk) blank <= 1'b1;
      @(posedge clk);
      #1;
      `PDS_CHK(serial_bit, 1'b1)
      @(posedge clk) blank <= 1'b0;
   endtask : mux_task

   // Losing power stops the clock and freezes counter and buffer.
   task automatic power_task();
      logic [3:0] sel;
      logic [15:0] held;
      @(posedge clk) power_good <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `PDS_CHK(panel_clk, 1'b0)
      sel = scan_select;
      held = lamp;
      repeat (300) @(posedge clk);
      #1;
      `PDS_CHK(scan_select, sel)
      `PDS_CHK(lamp, held)
      @(posedge clk) power_good <= 1'b1;
      @(posedge clk);
      #1;
      `PDS_CHK(panel_clk, 1'b1)
      `PDS_CHK(scan_select, sel - 4'h1)
   endtask : power_task

   // Clock enable low freezes the panel clock, the counter and the lamps.
   task automatic ce_task();
      logic [3:0] sel;
      logic [15:0] held;
      logic pclk;
      @(posedge clk) ce <= 1'b0;
      @(posedge clk);
      #1;
      sel = scan_select;
      held = lamp;
      pclk = panel_clk;
      repeat (300) @(posedge clk);
      #1;
      `PDS_CHK(scan_select, sel)
      `PDS_CHK(lamp, held)
      `PDS_CHK(panel_clk, pclk)
      @(posedge clk) ce <= 1'b1;
   endtask : ce_task

   // A full scan loads inverted data, the hold keeps it, strobe off gives 1s.
   task automatic scan_task();
      int n;
      logic [15:0] held;
      wait_level(1'b1, 1'b0, 30000, n);
      wait_level(1'b1, 1'b1, 30000, n);
      wait_level(1'b1, 1'b0, 2000, n);
      `PDS_CHK(n, 1600)
      `PDS_CHK(lamp, ~word)
      held = ~word;
      @(posedge clk) word <= 16'h0ff0;
      wait_level(1'b1, 1'b1, 30000, n);
      `PDS_CHK(n, 23999)
      `PDS_CHK(lamp, held)
      @(posedge clk) blank <= 1'b1;
      wait_level(1'b1, 1'b0, 2000, n);
      `PDS_CHK(n, 1599)
      `PDS_CHK(lamp, 16'hffff)
      @(posedge clk) blank <= 1'b0;
   endtask : scan_task

   // Main sequence: reset for 16 cycles, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      clock_task();
      mux_task();
      power_task();
      ce_task();
      scan_task();
      test_done();
   end

endmodule : pds_panel_display_scanner_tb
